/* File: rtl/aim_monitor.sv */
// Purpose: Per-channel range, burnout, max/min, alarms, averaging,
//          auto calibration timing and locate LED, behind APB.
// Assumes: Samples arrive from converter logic on pclk, one per channel.
// Notes:   Samples and open-circuit flags are same-clock inputs.
`timescale 1ns/1ns
module aim_monitor #(
  parameter longint LOCATE_CYCLES = aim_pkg::LOCATE_CYC,
  parameter longint CAL_CYCLES    = aim_pkg::CAL_CYC
) (
  input  wire logic                        pclk,
  input  wire logic                        presetn,
  input  wire logic                        psel,
  input  wire logic                        penable,
  input  wire logic                        pwrite,
  input  wire logic [11:0]                 paddr,
  input  wire logic [31:0]                 pwdata,
  output logic      [31:0]                 prdata,
  output logic                             pready,
  output logic                             pslverr,
  input  wire aim_pkg::aim_sample_s        sample [aim_pkg::NCH],
  output logic      [3:0]                  range_sel [aim_pkg::NCH],
  output logic                             integ_sel,
  output logic                             cal_active,
  output logic                             cal_commit,
  output logic                             status_led,
  output logic                             alarm_led,
  output logic                             irq
);
  import aim_pkg::*;

  logic [31:0]   ctrl;
  logic [31:0]   irq_stat;
  logic [31:0]   irq_mask;
  aim_cfg_s      cfg     [NCH];
  logic [DW-1:0] hi_lim  [NCH];
  logic [DW-1:0] lo_lim  [NCH];
  logic [DW-1:0] value   [NCH];
  logic [DW-1:0] max_v   [NCH];
  logic [DW-1:0] min_v   [NCH];
  logic          mm_prime[NCH];
  logic [NCH-1:0] hi_st;
  logic [NCH-1:0] lo_st;
  logic [NCH-1:0] hi_cond;
  logic [NCH-1:0] lo_cond;
  logic [DW-1:0] avg;
  logic [63:0]   loc_cnt;
  logic [63:0]   cal_cnt;
  aim_cal_e      cal_st;
  logic          cal_done_ev;
  logic          loc_end_ev;
  logic          alarm_rise_ev;
  logic          any_alarm_q;

  logic          wr_en;
  logic          rd_en;
  logic          ch_hit;
  logic [CW-1:0] ch_idx;
  logic [11:0]   ch_ofs;
  logic          apply_cmd;
  logic          calgo_cmd;

  assign wr_en  = psel & penable & pwrite;
  assign rd_en  = psel & penable & ~pwrite;
  assign ch_hit = (paddr >= CH_BASE) && (paddr < CH_BASE + 12'(NCH * 32));
  assign ch_idx = CW'((paddr - CH_BASE) >> 5);
  assign ch_ofs = {7'h00, paddr[4:0]};
  assign apply_cmd = wr_en && paddr == CMD_OFS && pwdata[CMD_APPLY];
  assign calgo_cmd = wr_en && paddr == CMD_OFS && pwdata[CMD_CALGO];
  // Zero wait states: every access finishes in its first access cycle
  assign pready = 1'b1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl <= CTRL_RST;
    end else if (wr_en && paddr == CTRL_OFS) begin
      ctrl <= pwdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_mask <= 32'h0000_0000;
    end else if (wr_en && paddr == IRQM_OFS) begin
      irq_mask <= {29'h0000_0000, pwdata[2:0]};
    end
  end

  // Range is staged in the channel config words and integration time in CTRL;
  // both only reach the converter on apply, so a half-written setup never shows.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      integ_sel <= 1'b0;
    end else if (apply_cmd) begin
      integ_sel <= ctrl[CTRL_ITSEL];
    end
  end

  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      logic wr_ch;
      logic clr_hit;
      logic cur_loop;
      logic val_fresh;
      assign wr_ch   = wr_en && ch_hit && ch_idx == CW'(g);
      assign clr_hit = wr_ch && ch_ofs == CH_CLR;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          cfg[g]    <= '{range: 4'h0, hi_mode: AM_DISABLE,
                         lo_mode: AM_DISABLE};
          hi_lim[g] <= LIM_HI_RST;
          lo_lim[g] <= LIM_LO_RST;
        end else if (wr_ch) begin
          if (ch_ofs == CH_CFG) begin
            cfg[g].range   <= pwdata[CFG_RNG_LO +: 4];
            cfg[g].hi_mode <= aim_amode_e'(pwdata[CFG_HIM_LO +: 2]);
            cfg[g].lo_mode <= aim_amode_e'(pwdata[CFG_LOM_LO +: 2]);
          end
          if (ch_ofs == CH_HILIM) hi_lim[g] <= pwdata[DW-1:0];
          if (ch_ofs == CH_LOLIM) lo_lim[g] <= pwdata[DW-1:0];
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          range_sel[g] <= 4'h0;
        end else if (apply_cmd) begin
          range_sel[g] <= cfg[g].range;
        end
      end

      assign cur_loop = range_sel[g] == RNG_CURRENT;

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          value[g] <= ALL_ZEROS;
        end else if (sample[g].valid) begin
          if (cur_loop && sample[g].open)
            value[g] <= ctrl[CTRL_BURNUP] ? ALL_ONES
                                          : ALL_ZEROS;
          else
            value[g] <= sample[g].data;
        end
      end

      // High in the cycle after a new sample has reached value[g]
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          val_fresh <= 1'b0;
        end else begin
          val_fresh <= sample[g].valid;
        end
      end

      // The first sample after reset loads both records; the reset value
      // of value[g] is no reading, so it must not seed them
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          mm_prime[g] <= 1'b1;
          max_v[g]    <= ALL_ZEROS;
          min_v[g]    <= ALL_ONES;
        end else begin
          if (clr_hit && pwdata[CLR_MAX]) begin
            max_v[g] <= value[g];
          end else if (val_fresh &&
                       (mm_prime[g] || value[g] > max_v[g])) begin
            max_v[g] <= value[g];
          end
          if (clr_hit && pwdata[CLR_MIN]) begin
            min_v[g] <= value[g];
          end else if (val_fresh &&
                       (mm_prime[g] || value[g] < min_v[g])) begin
            min_v[g] <= value[g];
          end
          if (val_fresh) mm_prime[g] <= 1'b0;
        end
      end

      // Limits compare against the reported, burnout-substituted value
      assign hi_cond[g] = value[g] > hi_lim[g];
      assign lo_cond[g] = value[g] < lo_lim[g];

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          hi_st[g] <= 1'b0;
        end else begin
          unique case (cfg[g].hi_mode)
            AM_LATCH:     hi_st[g] <= hi_cond[g] |
                                      (hi_st[g] & ~(clr_hit & pwdata[CLR_HI]));
            AM_MOMENTARY: hi_st[g] <= hi_cond[g];
            default:      hi_st[g] <= 1'b0;
          endcase
        end
      end

      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          lo_st[g] <= 1'b0;
        end else begin
          unique case (cfg[g].lo_mode)
            AM_LATCH:     lo_st[g] <= lo_cond[g] |
                                      (lo_st[g] & ~(clr_hit & pwdata[CLR_LO]));
            AM_MOMENTARY: lo_st[g] <= lo_cond[g];
            default:      lo_st[g] <= 1'b0;
          endcase
        end
      end
    end
  endgenerate

  // Average: sum over selected channels divided by the count selected.
  // A divider is cheap at 8 channels and avoids power-of-two restrictions.
  logic [DW+CW:0] avg_sum;
  logic [CW:0]    avg_n;
  always_comb begin
    avg_sum = '0;
    avg_n   = '0;
    for (int i = 0; i < NCH; i++) begin
      if (ctrl[CTRL_AVGEN + i]) begin
        avg_sum = avg_sum + (DW+CW+1)'(value[i]);
        avg_n   = avg_n + (CW+1)'(1);
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      avg <= ALL_ZEROS;
    end else begin
      avg <= (avg_n == '0) ? ALL_ZEROS
                           : DW'(avg_sum / (DW+CW+1)'(avg_n));
    end
  end

  assign alarm_led = |{hi_st, lo_st};

  // Locate: a write of one restarts the ten second window
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      loc_cnt    <= 64'h0;
      loc_end_ev <= 1'b0;
    end else begin
      loc_end_ev <= 1'b0;
      if (wr_en && paddr == CTRL_OFS && pwdata[CTRL_LOCATE]) begin
        loc_cnt <= 64'(LOCATE_CYCLES);
      end else if (loc_cnt != 64'h0) begin
        loc_cnt <= loc_cnt - 64'h1;
        loc_end_ev <= loc_cnt == 64'h1;
      end
    end
  end

  assign status_led = loc_cnt != 64'h0;

  // Calibration runs only when allowed; commit waits for the host apply
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cal_st      <= CAL_IDLE;
      cal_cnt     <= 64'h0;
      cal_commit  <= 1'b0;
      cal_done_ev <= 1'b0;
    end else begin
      cal_commit  <= 1'b0;
      cal_done_ev <= 1'b0;
      unique case (cal_st)
        CAL_IDLE: if (calgo_cmd && ctrl[CTRL_CALOK]) begin
          cal_st  <= CAL_RUN;
          cal_cnt <= 64'(CAL_CYCLES);
        end
        CAL_RUN: begin
          cal_cnt <= cal_cnt - 64'h1;
          if (cal_cnt == 64'h1) begin
            cal_st      <= CAL_WAIT;
            cal_done_ev <= 1'b1;
          end
        end
        CAL_WAIT: if (apply_cmd) begin
          cal_st     <= CAL_IDLE;
          cal_commit <= 1'b1;
        end
        default: cal_st <= CAL_IDLE;
      endcase
    end
  end

  assign cal_active = cal_st == CAL_RUN;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      any_alarm_q <= 1'b0;
    end else begin
      any_alarm_q <= alarm_led;
    end
  end
  assign alarm_rise_ev = alarm_led & ~any_alarm_q;

  // Hardware set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 32'h0000_0000;
    end else begin
      if (wr_en && paddr == IRQS_OFS) irq_stat <= irq_stat & ~pwdata;
      if (cal_done_ev)   irq_stat[IRQ_CALDONE] <= 1'b1;
      if (alarm_rise_ev) irq_stat[IRQ_ALARM]   <= 1'b1;
      if (loc_end_ev)    irq_stat[IRQ_LOCEND]  <= 1'b1;
    end
  end

  // A set mask bit holds its event off the interrupt line
  assign irq = |(irq_stat & ~irq_mask);

  always_comb begin
    prdata  = 32'h0000_0000;
    pslverr = 1'b0;
    if (ch_hit) begin
      unique case (ch_ofs)
        CH_CFG:   prdata = {24'h0, cfg[ch_idx].lo_mode, cfg[ch_idx].hi_mode,
                            cfg[ch_idx].range};
        CH_HILIM: prdata = {16'h0, hi_lim[ch_idx]};
        CH_LOLIM: prdata = {16'h0, lo_lim[ch_idx]};
        CH_VAL:   prdata = {16'h0, value[ch_idx]};
        CH_MAX:   prdata = {16'h0, max_v[ch_idx]};
        CH_MIN:   prdata = {16'h0, min_v[ch_idx]};
        CH_CLR:   prdata = 32'h0000_0000;
        default:  pslverr = psel & penable;
      endcase
    end else begin
      unique case (paddr)
        CTRL_OFS: prdata = ctrl;
        CMD_OFS:  prdata = 32'h0000_0000;
        STAT_OFS: prdata = {24'h0, 2'b00, status_led, alarm_led,
                            integ_sel, 1'b0, cal_st};
        IRQS_OFS: prdata = irq_stat;
        IRQM_OFS: prdata = irq_mask;
        AVG_OFS:  prdata = {16'h0, avg};
        ALRM_OFS: prdata = {16'h0, lo_st, hi_st};
        default:  pslverr = psel & penable;
      endcase
    end
    if (!rd_en) prdata = 32'h0000_0000;
  end
endmodule : aim_monitor

/* File: rtl/aim_pkg.sv */
// Purpose: Shared constants and types for the analog input alarm monitor.
// Assumes: APB with 32-bit data, pclk at 100 MHz.
// Notes:   Offsets are byte addresses; per-channel blocks stride 0x20.
package aim_pkg;
  localparam int NCH = 8;
  localparam int CW  = 3;
  localparam int DW  = 16;
  localparam int CLK_HZ = 100_000_000;
  localparam int LOCATE_S = 10;
  localparam int CAL_S    = 20;
  localparam longint LOCATE_CYC = longint'(LOCATE_S) * CLK_HZ;
  localparam longint CAL_CYC    = longint'(CAL_S) * CLK_HZ;
  // Global registers
  localparam logic [11:0] CTRL_OFS  = 12'h000;
  localparam logic [11:0] CMD_OFS   = 12'h004;
  localparam logic [11:0] STAT_OFS  = 12'h008;
  localparam logic [11:0] IRQS_OFS  = 12'h00c;
  localparam logic [11:0] IRQM_OFS  = 12'h010;
  localparam logic [11:0] AVG_OFS   = 12'h014;
  localparam logic [11:0] ALRM_OFS  = 12'h018;
  // Per-channel block base and word offsets
  localparam logic [11:0] CH_BASE   = 12'h100;
  localparam logic [11:0] CH_CFG    = 12'h000;
  localparam logic [11:0] CH_HILIM  = 12'h004;
  localparam logic [11:0] CH_LOLIM  = 12'h008;
  localparam logic [11:0] CH_VAL    = 12'h00c;
  localparam logic [11:0] CH_MAX    = 12'h010;
  localparam logic [11:0] CH_MIN    = 12'h014;
  localparam logic [11:0] CH_CLR    = 12'h018;
  // CTRL fields
  localparam int CTRL_LOCATE = 0;
  localparam int CTRL_CALOK  = 1;
  localparam int CTRL_BURNUP = 2;
  localparam int CTRL_ITSEL  = 3;
  localparam int CTRL_AVGEN  = 8;
  // CMD fields (write-one pulses)
  localparam int CMD_APPLY   = 0;
  localparam int CMD_CALGO   = 1;
  // CH_CFG fields
  localparam int CFG_RNG_LO  = 0;
  localparam int CFG_HIM_LO  = 4;
  localparam int CFG_LOM_LO  = 6;
  // CH_CLR fields
  localparam int CLR_MAX = 0;
  localparam int CLR_MIN = 1;
  localparam int CLR_HI  = 2;
  localparam int CLR_LO  = 3;
  // IRQ status bits
  localparam int IRQ_CALDONE = 0;
  localparam int IRQ_ALARM   = 1;
  localparam int IRQ_LOCEND  = 2;
  localparam logic [31:0] CTRL_RST = 32'h0000_0000;
  localparam logic [DW-1:0] LIM_HI_RST = 16'hffff;
  localparam logic [DW-1:0] LIM_LO_RST = 16'h0000;
  localparam logic [DW-1:0] ALL_ONES   = 16'hffff;
  localparam logic [DW-1:0] ALL_ZEROS  = 16'h0000;
  localparam logic [3:0] RNG_CURRENT = 4'h7;

  typedef enum logic [1:0] {
    AM_DISABLE   = 2'b00,
    AM_LATCH     = 2'b01,
    AM_MOMENTARY = 2'b11
  } aim_amode_e;

  typedef enum logic [1:0] {
    CAL_IDLE = 2'b00,
    CAL_RUN  = 2'b01,
    CAL_WAIT = 2'b11
  } aim_cal_e;

  typedef struct packed {
    logic [DW-1:0] data;
    logic          open;
    logic          valid;
  } aim_sample_s;

  typedef struct packed {
    logic [3:0] range;
    aim_amode_e hi_mode;
    aim_amode_e lo_mode;
  } aim_cfg_s;
endpackage : aim_pkg

/* File: tb/aim_adc_model.sv */
// Purpose: Converter model that delivers one sample per request.
// Assumes: Requests are issued just after a clock edge.
// Notes:   Stale fields are inverted so nothing reads as valid data.
`timescale 1ns/1ns
module aim_adc_model (
  input  wire logic          pclk,
  output aim_pkg::aim_sample_s sample [aim_pkg::NCH]
);
  import aim_pkg::*;
  initial foreach (sample[i]) sample[i] = '0;
  task automatic put(input int c, input logic [15:0] d, input logic o);
    @(posedge pclk);
    sample[c] <= '{data: d, open: o, valid: 1'b1};
    @(posedge pclk);
    sample[c] <= '{data: ~d, open: ~o, valid: 1'b0};
  endtask : put
endmodule : aim_adc_model

/* File: tb/aim_monitor_checker.sv */
// Purpose: Port-level timing checks for the alarm monitor.
// Assumes: Zero-wait APB; writes land at the access edge.
// Notes:   Durations allow one cycle of slack at the start edge.
`timescale 1ns/1ns
module aim_monitor_checker
  import aim_pkg::*;
#(
  parameter longint LOCATE_CYCLES = 20,
  parameter longint CAL_CYCLES    = 40
) (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic        pslverr,
  input wire logic [3:0]  range_sel [NCH],
  input wire logic        integ_sel,
  input wire logic        cal_active,
  input wire logic        cal_commit,
  input wire logic        status_led,
  input wire logic        alarm_led
);
  longint led_n;
  longint cal_n;
  logic   acc;
  logic   apply_wr;
  assign acc      = psel && penable && pwrite;
  assign apply_wr = acc && paddr == CMD_OFS && pwdata[CMD_APPLY];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led_n <= 0;
      cal_n <= 0;
    end else begin
      led_n <= status_led ? led_n + 1 : 0;
      cal_n <= cal_active ? cal_n + 1 : 0;
    end
  end
  a_locate_start: assert property (acc && paddr == CTRL_OFS &&
    pwdata[CTRL_LOCATE] |-> ##[1:2] status_led)
    else $error("locate write did not light status LED");
  a_locate_len: assert property ($fell(status_led) |->
    led_n inside {[LOCATE_CYCLES-1:LOCATE_CYCLES+1]})
    else $error("status LED window has wrong length");
  a_cal_len: assert property ($fell(cal_active) |->
    cal_n inside {[CAL_CYCLES-1:CAL_CYCLES+1]})
    else $error("calibration run has wrong length");
  a_commit_pulse: assert property (cal_commit |=> !cal_commit)
    else $error("commit pulse longer than one cycle");
  a_commit_cause: assert property ($rose(cal_commit) |->
    $past(apply_wr))
    else $error("commit without apply");
  a_integ_apply: assert property ($changed(integ_sel) |->
    $past(apply_wr))
    else $error("integration time changed without apply");
  a_range_apply: assert property ($changed(range_sel[0]) |->
    $past(apply_wr))
    else $error("range changed without apply");
  a_unmapped_err: assert property (psel && penable &&
    paddr == 12'h01c |-> pslverr)
    else $error("unmapped access without error");
  a_reset_quiet: assert property ($rose(presetn) |->
    !alarm_led && !status_led)
    else $error("indications set after reset");
  c_locate: cover property ($rose(status_led));
  c_commit: cover property ($rose(cal_commit));
  c_alarm:  cover property ($rose(alarm_led));
endmodule : aim_monitor_checker

bind aim_monitor aim_monitor_checker #(
  .LOCATE_CYCLES(LOCATE_CYCLES),
  .CAL_CYCLES(CAL_CYCLES)
) chk_i (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pslverr(pslverr),
  .range_sel(range_sel), .integ_sel(integ_sel),
  .cal_active(cal_active), .cal_commit(cal_commit),
  .status_led(status_led), .alarm_led(alarm_led)
);

/* File: tb/aim_monitor_tb.sv */
// Purpose: Self-checking bench for the alarm monitor over APB.
// Assumes: Mask bit set means the event is held off the interrupt.
// Notes:   Long counts shortened through the design parameters.
`timescale 1ns/1ns
module aim_monitor_tb;
  import aim_pkg::*;
  localparam longint LOC = 20;
  localparam longint CAL = 40;
  logic              pclk, presetn, psel, penable, pwrite;
  logic [11:0]       paddr;
  logic [31:0]       pwdata, prdata;
  logic              pready, pslverr, integ_sel, cal_active, cal_commit;
  logic              status_led, alarm_led, irq;
  aim_sample_s       sample [NCH];
  logic [3:0]        range_sel [NCH];
  logic [44:0]       expq [$];
  int                mismatches, samples_checked;
  logic [15:0]       v, mx, mn, a, b;

  aim_monitor #(.LOCATE_CYCLES(LOC), .CAL_CYCLES(CAL)) aim_monitor_i (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .sample(sample),
    .range_sel(range_sel), .integ_sel(integ_sel),
    .cal_active(cal_active), .cal_commit(cal_commit),
    .status_led(status_led), .alarm_led(alarm_led), .irq(irq));
  aim_adc_model aim_adc_model_i (.pclk(pclk), .sample(sample));

  task automatic chk(input string nm, input logic [32:0] seen, exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s exp %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic final_report;
    $display("checked %0d mismatches %0d", samples_checked, mismatches);
    if (mismatches == 0 && samples_checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : final_report
  task automatic xfer(input logic w, input logic [11:0] ad,
                      input logic [31:0] d);
    psel <= 1; pwrite <= w; paddr <= ad; pwdata <= d; penable <= 0;
    @(posedge pclk);
    penable <= 1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 0; penable <= 0;
    // Idle edge, so a following call never reassigns psel in this step
    @(posedge pclk);
  endtask : xfer
  task automatic wr(input logic [11:0] ad, input logic [31:0] d);
    xfer(1, ad, d);
  endtask : wr
  task automatic rd(input logic [11:0] ad, input logic [31:0] e,
                    input logic er = 0);
    expq.push_back({er, ad, e});
    xfer(0, ad, 32'h0);
  endtask : rd
  task automatic tick(input int n = 1);
    repeat (n) @(posedge pclk);
  endtask : tick
  task automatic put(input int c, input logic [15:0] d, input logic o);
    aim_adc_model_i.put(c, d, o);
    tick(3);
  endtask : put
  function automatic logic [11:0] ca(input int c, input logic [11:0] o);
    return CH_BASE + 12'(c * 32) + o;
  endfunction : ca
  task automatic alarm_case(input int lo, input logic [1:0] m);
    logic [31:0] s;
    s = m[0] ? 32'h1 << (2 + 8 * lo) : 32'h0;
    wr(ca(2, CH_CFG), 32'(m) << (lo ? CFG_LOM_LO : CFG_HIM_LO));
    put(2, 16'h8000, 0);
    rd(ALRM_OFS, 0);
    put(2, lo ? 16'h7fff : 16'h8001, 0);
    rd(ALRM_OFS, s);
    chk("alarm_led", 33'(alarm_led), 33'(s != 0));
    put(2, 16'h8000, 0);
    rd(ALRM_OFS, m == 2'b01 ? s : 0);
    wr(ca(2, CH_CLR), 32'h4 << lo);
    rd(ALRM_OFS, 0);
  endtask : alarm_case

  // Reads are judged where the data appears, oldest note first
  always @(posedge pclk) begin
    logic [44:0] e;
    if (psel && penable && pready && !pwrite && expq.size() > 0) begin
      e = expq.pop_front();
      chk($sformatf("rd %h", e[43:32]), {pslverr, prdata},
          {e[44], e[31:0]});
    end
  end
  initial begin
    pclk = 0;
    forever #5 pclk = ~pclk;
  end
  initial begin
    tick(20000);
    mismatches++;
    final_report();
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
    void'($urandom(16));
    tick(10);
    presetn <= 1;
    tick();
    rd(CTRL_OFS, 0);
    rd(ca(0, CH_HILIM), 32'hffff);
    rd(ca(0, CH_LOLIM), 32'h0);
    rd(12'h01c, 0, 1);
    $display("test registers done");
    v = 16'($urandom);
    wr(ca(0, CH_CFG), 32'(RNG_CURRENT));
    put(0, v, 1);
    rd(ca(0, CH_VAL), 32'(v));
    wr(CMD_OFS, 32'h1);
    tick();
    chk("range", 33'(range_sel[0]), 33'(RNG_CURRENT));
    wr(CTRL_OFS, 32'h4);
    put(0, v, 1);
    rd(ca(0, CH_VAL), 32'hffff);
    wr(CTRL_OFS, 32'h0);
    put(0, v, 1);
    rd(ca(0, CH_VAL), 32'h0);
    $display("test burnout done");
    for (int i = 0; i < 6; i++) begin
      v = 16'($urandom);
      if (i == 0 || v > mx) mx = v;
      if (i == 0 || v < mn) mn = v;
      put(1, v, 0);
    end
    rd(ca(1, CH_MAX), 32'(mx));
    rd(ca(1, CH_MIN), 32'(mn));
    wr(ca(1, CH_CLR), 32'h3);
    tick(2);
    rd(ca(1, CH_MAX), 32'(v));
    rd(ca(1, CH_MIN), 32'(v));
    $display("test max min done");
    wr(ca(2, CH_HILIM), 32'h8000);
    wr(ca(2, CH_LOLIM), 32'h8000);
    for (int m = 0; m < 4; m++)
      for (int lo = 0; lo < 2; lo++) alarm_case(lo, 2'(m));
    $display("test alarms done");
    a = 16'($urandom);
    b = 16'($urandom);
    put(4, a, 0);
    put(5, b, 0);
    wr(CTRL_OFS, 32'h3000);
    tick(2);
    rd(AVG_OFS, 32'(({1'b0, a} + b) >> 1));
    wr(CTRL_OFS, 32'h8);
    tick();
    chk("integ", 33'(integ_sel), 33'h0);
    wr(CMD_OFS, 32'h1);
    tick();
    chk("integ", 33'(integ_sel), 33'h1);
    $display("test average integ done");
    wr(IRQS_OFS, 32'h7);
    wr(CTRL_OFS, 32'h8 | 32'h1);
    tick();
    chk("led", 33'(status_led), 33'h1);
    tick(int'(LOC) + 2);
    chk("led", 33'(status_led), 33'h0);
    rd(IRQS_OFS, 32'h4);
    wr(IRQM_OFS, 32'h4);
    tick();
    chk("irq", 33'(irq), 33'h0);
    wr(IRQM_OFS, 32'h0);
    tick();
    chk("irq", 33'(irq), 33'h1);
    wr(IRQS_OFS, 32'h4);
    tick();
    chk("irq", 33'(irq), 33'h0);
    $display("test locate done");
    wr(CMD_OFS, 32'h2);
    tick();
    chk("cal", 33'(cal_active), 33'h0);
    wr(CTRL_OFS, 32'h8 | 32'h2);
    wr(CMD_OFS, 32'h2);
    tick();
    chk("cal", 33'(cal_active), 33'h1);
    tick(int'(CAL) + 2);
    chk("cal", 33'(cal_active), 33'h0);
    rd(STAT_OFS, 32'hb);
    wr(CMD_OFS, 32'h1);
    rd(STAT_OFS, 32'h8);
    rd(IRQS_OFS, 32'h1);
    $display("test calibration done");
    wr(ca(2, CH_CFG), 32'h10);
    put(2, 16'h8001, 0);
    rd(ALRM_OFS, 32'h4);
    presetn <= 0;
    tick(2);
    presetn <= 1;
    tick();
    rd(ALRM_OFS, 0);
    put(2, 16'h1234, 0);
    rd(ca(2, CH_MAX), 32'h1234);
    rd(ca(2, CH_MIN), 32'h1234);
    $display("test reset done");
    final_report();
  end
endmodule : aim_monitor_tb
